// [hdl/adcc_pkg.sv]
package adcc_pkg;

   // ---------------------------------------------------------------
   // register map (word indices taken from haddr[5:2], one word each)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADCC_IDX_CTRL = 4'h0;
   localparam logic [3:0] ADCC_IDX_SEL = 4'h1;
   localparam logic [3:0] ADCC_IDX_STAT = 4'h2;

   // control_status_a fields
   localparam int ADCC_EN_POS = 0;
   localparam int ADCC_START_POS = 1;
   localparam int ADCC_AUTO_POS = 2;
   localparam int ADCC_DONE_POS = 3;
   localparam int ADCC_IE_POS = 4;
   localparam int ADCC_FREE_POS = 5;
   localparam int ADCC_DIV_POS = 6;

   // input_select_reg fields
   localparam int ADCC_CHAN_POS = 0;
   localparam int ADCC_REF_POS = 6;

   // reset values
   localparam logic [2:0] ADCC_DIV_RESET = 3'h0;
   localparam logic [4:0] ADCC_CHAN_RESET = 5'h00;
   localparam logic [1:0] ADCC_REF_RESET = 2'h0;

   // channel codes from here upward select a differential pair
   localparam logic [4:0] ADCC_DIFF_FIRST = 5'h08;

   // ---------------------------------------------------------------
   // conversion lengths and sample points, in converter clocks
   // ---------------------------------------------------------------
   localparam logic [4:0] ADCC_LEN_FIRST = 5'd25;
   localparam logic [4:0] ADCC_LEN_SYNC = 5'd14;
   localparam logic [4:0] ADCC_LEN_NORMAL = 5'd13;
   localparam logic [4:0] ADCC_SH_FIRST = 5'd13;
   localparam logic [4:0] ADCC_SH_SYNC = 5'd2;
   localparam logic [4:0] ADCC_SH_NORMAL = 5'd1;

   localparam int ADCC_PRE_W = 7;

   typedef enum logic [1:0] {
      ADCC_SLP_ACTIVE = 2'b00,
      ADCC_SLP_IDLE = 2'b01,
      ADCC_SLP_NOISE = 2'b10,
      ADCC_SLP_OTHER = 2'b11
   } adcc_sleep_type;

   typedef enum logic [1:0] {
      ADCC_ST_IDLE = 2'b00,
      ADCC_ST_WAIT = 2'b01,
      ADCC_ST_CONV = 2'b10
   } adcc_conv_type;

endpackage

// [hdl/adcc_tick_gen.sv]
`timescale 1ns/1ps
module adcc_tick_gen
   import adcc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic run_in,
   input wire logic restart_in,
   input wire logic [2:0] div_sel_in,
   output logic tick_out,
   output logic half_out
);

   typedef struct packed {
      logic [ADCC_PRE_W-1:0] count;
      logic tick;
      logic half;
   } adcc_tick_type;

   adcc_tick_type st, next_st;
   logic [7:0] limit;

   // -------------------------------------------------------------
   // prescaler and half-rate clock
   // -------------------------------------------------------------
   // divide by 2, 4 ... 128 of the system clock
   always_comb begin
      limit = (8'd2 << div_sel_in) - 8'd1;
      next_st = st;
      next_st.tick = 1'b0;
      if (!run_in || restart_in) begin
         next_st.count = '0;
         next_st.half = 1'b0;
      end else if (st.count == limit[ADCC_PRE_W-1:0]) begin
         next_st.count = '0;
         next_st.tick = 1'b1;
         next_st.half = ~st.half;
      end else begin
         next_st.count = st.count + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         st <= '0;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   assign tick_out = st.tick;
   assign half_out = st.half;

endmodule // adcc_tick_gen

// [hdl/adcc_control.sv]
`timescale 1ns/1ps
module adcc_control
   import adcc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic trigger_in,
   input wire logic [1:0] sleep_mode_in,
   input wire logic cpu_halted_in,
   input wire logic test_if_enable_in,
   output logic [6:0] applied_select_out,
   output logic conv_active_out,
   output logic sample_hold_out,
   output logic conv_irq_out,
   output logic half_rate_conv_clock_out,
   output logic [3:0] analog_port_upper_pins_out
);

   typedef struct packed {
      logic converter_enable;
      logic start_conversion_bit;
      logic auto_trigger_enable;
      logic conversion_done_flag;
      logic irq_enable;
      logic free_run_src;
      logic [2:0] div_sel;
      logic [4:0] channel_select_bits;
      logic [1:0] reference_select_bits;
      logic [6:0] applied;
      adcc_conv_type cs;
      logic [4:0] count;
      logic [4:0] len;
      logic [4:0] sh;
      logic first;
      logic trig_q;
      logic slp_armed;
      logic test_s1;
      logic test_s2;
      logic sample;
      logic wr_pend;
      logic [3:0] wr_idx;
      logic [31:0] rdata;
   } adcc_state_type;

   adcc_state_type st, next_st;
   logic tick, half, restart, addr_ok, diff, slp_ok, done_now;
   logic [4:0] cnt_inc;

   // -------------------------------------------------------------
   // converter clock source
   // -------------------------------------------------------------
   adcc_tick_gen u_tick (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .ce_in(ce_in),
      .run_in(st.converter_enable),
      .restart_in(restart),
      .div_sel_in(st.div_sel),
      .tick_out(tick),
      .half_out(half)
   );

   // -------------------------------------------------------------
   // next-state logic
   // -------------------------------------------------------------
   // word accesses only; other sizes still decode, low lanes used
   assign addr_ok = hsel_in && htrans_in[1] && hready_in;
   assign diff = st.channel_select_bits >= ADCC_DIFF_FIRST;
   assign cnt_inc = st.count + 5'd1;
   assign done_now = (st.cs == ADCC_ST_CONV) && tick && (cnt_inc == st.len);
   assign slp_ok = st.converter_enable && (st.cs == ADCC_ST_IDLE)
      && !st.start_conversion_bit && !st.auto_trigger_enable && st.irq_enable
      && cpu_halted_in && !st.slp_armed
      && (sleep_mode_in == ADCC_SLP_IDLE || sleep_mode_in == ADCC_SLP_NOISE);
   assign restart = st.converter_enable && st.auto_trigger_enable
      && !st.free_run_src && trigger_in && !st.trig_q && (st.cs == ADCC_ST_IDLE);

   always_comb begin
      next_st = st;
      next_st.sample = 1'b0;
      next_st.trig_q = trigger_in;
      next_st.test_s1 = test_if_enable_in;
      next_st.test_s2 = st.test_s1;
      // bus data phase: write lands now
      next_st.wr_pend = addr_ok && hwrite_in;
      next_st.wr_idx = haddr_in[5:2];
      if (st.wr_pend) begin
         case (st.wr_idx)
            ADCC_IDX_CTRL: begin
               next_st.converter_enable = hwdata_in[ADCC_EN_POS];
               next_st.auto_trigger_enable = hwdata_in[ADCC_AUTO_POS];
               next_st.irq_enable = hwdata_in[ADCC_IE_POS];
               next_st.free_run_src = hwdata_in[ADCC_FREE_POS];
               next_st.div_sel = hwdata_in[ADCC_DIV_POS +: 3];
               if (hwdata_in[ADCC_START_POS] && hwdata_in[ADCC_EN_POS])
                  next_st.start_conversion_bit = 1'b1;
               if (hwdata_in[ADCC_DONE_POS])
                  next_st.conversion_done_flag = 1'b0;
            end
            ADCC_IDX_SEL: begin
               next_st.channel_select_bits = hwdata_in[ADCC_CHAN_POS +: 5];
               next_st.reference_select_bits = hwdata_in[ADCC_REF_POS +: 2];
            end
            default: begin
            end
         endcase
      end
      // release the sleep start once the cpu is running again
      if (!cpu_halted_in || sleep_mode_in == ADCC_SLP_ACTIVE)
         next_st.slp_armed = 1'b0;
      case (st.cs)
         ADCC_ST_IDLE: begin
            if (restart) begin
               next_st.start_conversion_bit = 1'b1;
               next_st.cs = ADCC_ST_WAIT;
            end else if (slp_ok) begin
               next_st.start_conversion_bit = 1'b1;
               next_st.slp_armed = 1'b1;
               next_st.cs = ADCC_ST_WAIT;
            end else if (st.start_conversion_bit) begin
               next_st.cs = ADCC_ST_WAIT;
            end
         end
         ADCC_ST_WAIT: begin
            // begin on the converter clock edge
            if (tick) begin
               next_st.cs = ADCC_ST_CONV;
               next_st.count = 5'd0;
               next_st.first = 1'b0;
               if (st.first) begin
                  next_st.len = ADCC_LEN_FIRST;
                  next_st.sh = ADCC_SH_FIRST;
               end else if (diff && half) begin
                  next_st.len = ADCC_LEN_SYNC;
                  next_st.sh = ADCC_SH_SYNC;
               end else begin
                  next_st.len = ADCC_LEN_NORMAL;
                  next_st.sh = ADCC_SH_NORMAL;
               end
            end
         end
         ADCC_ST_CONV: begin
            if (tick) begin
               next_st.count = cnt_inc;
               if (cnt_inc == st.sh)
                  next_st.sample = 1'b1;
               if (done_now) begin
                  if (st.auto_trigger_enable && st.free_run_src) begin
                     next_st.count = 5'd0;
                     next_st.len = diff ? ADCC_LEN_SYNC : ADCC_LEN_NORMAL;
                     next_st.sh = diff ? ADCC_SH_SYNC : ADCC_SH_NORMAL;
                  end else begin
                     next_st.start_conversion_bit = 1'b0;
                     next_st.cs = ADCC_ST_IDLE;
                  end
               end
            end
         end
         default: next_st.cs = ADCC_ST_IDLE;
      endcase
      // flag sets on completion; set wins over clear
      if (done_now)
         next_st.conversion_done_flag = 1'b1;
      // follow unless locked by a running conversion
      // a free-run restart relocks with the copy just taken
      // updates made while idle reach the next conversion
      if (st.cs != ADCC_ST_CONV || st.count >= st.len - 5'd1)
         next_st.applied = {st.reference_select_bits, st.channel_select_bits};
      // only software disable stops the converter
      if (!next_st.converter_enable) begin
         next_st.cs = ADCC_ST_IDLE;
         next_st.start_conversion_bit = 1'b0;
         next_st.first = 1'b1;
         // an aborted conversion leaves no stale count in the status word
         next_st.count = 5'd0;
      end
      // register read data in the address phase
      next_st.rdata = 32'h0000_0000;
      if (addr_ok && !hwrite_in) begin
         case (haddr_in[5:2])
            ADCC_IDX_CTRL: next_st.rdata[8:0] = {st.div_sel, st.free_run_src,
               st.irq_enable, st.conversion_done_flag, st.auto_trigger_enable,
               st.start_conversion_bit, st.converter_enable};
            ADCC_IDX_SEL: next_st.rdata[7:0] = {st.reference_select_bits,
               1'b0, st.channel_select_bits};
            ADCC_IDX_STAT: next_st.rdata[15:0] = {st.applied, st.cs,
               half, st.first, st.count};
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------
   // state register
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         st <= '0;
         st.first <= 1'b1;
         st.div_sel <= ADCC_DIV_RESET;
         st.channel_select_bits <= ADCC_CHAN_RESET;
         st.reference_select_bits <= ADCC_REF_RESET;
         st.cs <= ADCC_ST_IDLE;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // zero wait states, always okay
   assign hrdata_out = st.rdata;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign applied_select_out = st.applied;
   assign conv_active_out = st.cs == ADCC_ST_CONV;
   assign sample_hold_out = st.sample;
   // request wakes the cpu or follows another wake
   assign conv_irq_out = st.conversion_done_flag && st.irq_enable;
   assign half_rate_conv_clock_out = half;

   // test interface takes the upper pins
   for (genvar i = 0; i < 4; i++) begin : g_pin
      assign analog_port_upper_pins_out[i] = !st.test_s2;
   end

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   done_flag_set_a: assert property (
      @(posedge clk_sys_in) disable iff (reset_in || !ce_in)
      done_now |=> st.conversion_done_flag)
      else $error("done flag not set at completion");

   start_cleared_a: assert property (
      @(posedge clk_sys_in) disable iff (reset_in || !ce_in)
      done_now && !st.free_run_src && st.converter_enable |=> !st.start_conversion_bit)
      else $error("start bit not cleared at completion");

   select_locked_a: assert property (
      @(posedge clk_sys_in) disable iff (reset_in || !ce_in)
      st.cs == ADCC_ST_CONV && st.count < st.len - 5'd1 |=> $stable(st.applied))
      else $error("selection changed during conversion");

   select_follow_a: assert property (
      @(posedge clk_sys_in) disable iff (reset_in || !ce_in)
      st.cs == ADCC_ST_CONV && st.count == st.len - 5'd1
      |=> st.applied == $past({st.reference_select_bits, st.channel_select_bits}))
      else $error("selection not copied in last clock");

   first_len_a: assert property (
      @(posedge clk_sys_in) disable iff (reset_in || !ce_in)
      st.cs == ADCC_ST_WAIT && tick && st.first && st.converter_enable
      |=> st.len == 5'd25 && st.cs == ADCC_ST_CONV)
      else $error("first conversion not 25 clocks");

   sync_len_a: assert property (
      @(posedge clk_sys_in) disable iff (reset_in || !ce_in)
      st.cs == ADCC_ST_WAIT && tick && !st.first && diff && half && st.converter_enable
      |=> st.len == 5'd14)
      else $error("synchronised start not 14 clocks");

   presc_hold_a: assert property (
      @(posedge clk_sys_in) disable iff (reset_in || !ce_in)
      !st.converter_enable ##1 !st.converter_enable |-> !tick && !half)
      else $error("prescaler ran while disabled");

   sleep_start_a: assert property (
      @(posedge clk_sys_in) disable iff (reset_in || !ce_in)
      slp_ok && !restart && !(st.wr_pend && st.wr_idx == ADCC_IDX_CTRL)
      |=> st.cs == ADCC_ST_WAIT ##[1:130] st.cs == ADCC_ST_CONV)
      else $error("sleep start did not begin conversion");

   pin_override_a: assert property (
      @(posedge clk_sys_in) disable iff (reset_in || !ce_in)
      test_if_enable_in ##1 test_if_enable_in ##1 test_if_enable_in
      |-> analog_port_upper_pins_out == 4'h0)
      else $error("test interface did not take the pins");

endmodule // adcc_control

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
   import adcc_pkg::*;
   logic clk_sys_in, reset_in, hsel, hwrite, hready, hresp, trig, halted, tif;
   logic sh, irq, half, active, ce;
   logic [1:0] htrans, sleep;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [6:0] applied;
   logic [3:0] pins;
   int fails = 0, n_compared = 0, cyc = 0, t0, t1, t2, t3;

   adcc_control adcc_control_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(ce),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp), .trigger_in(trig), .sleep_mode_in(sleep),
      .cpu_halted_in(halted), .test_if_enable_in(tif), .applied_select_out(applied),
      .conv_active_out(active), .sample_hold_out(sh), .conv_irq_out(irq),
      .half_rate_conv_clock_out(half), .analog_port_upper_pins_out(pins));

   // -------------------------------------------------------------
   // clock, cycle count and hang guard
   // -------------------------------------------------------------
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   // the whole run needs under a thousand cycles; the ceiling leaves a wide margin
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end

   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one single-word transfer; read data taken at the edge that ends the data phase
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
      @(posedge clk_sys_in);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'b010;
      do @(posedge clk_sys_in); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk_sys_in); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0000_0000);
      chk(rd, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask

   // waits until the converting level equals lvl, notes the cycle in t0
   task automatic wait_active(input logic lvl);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys_in);
         n++;
      end while (active !== lvl && n < 400);
      chk({31'h0, active}, {31'h0, lvl});
      t0 = cyc;
   endtask

   task automatic conv_len(output int len);
      wait_active(1'b1);
      t1 = t0;
      wait_active(1'b0);
      len = t0 - t1;
   endtask

   task automatic wait_sh(output int t);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys_in);
         n++;
      end while (sh !== 1'b1 && n < 400);
      chk({31'h0, sh}, 32'h1);
      t = cyc;
   endtask

   task automatic pulse_trig();
      @(posedge clk_sys_in);
      trig <= 1'b1;
      @(posedge clk_sys_in);
      trig <= 1'b0;
   endtask

   // waits at a falling edge for the half-rate clock to have just turned to lvl
   task automatic wait_half(input logic lvl);
      logic prev;
      prev = half;
      @(negedge clk_sys_in);
      while (!(half === lvl && prev !== lvl)) begin
         prev = half;
         @(negedge clk_sys_in);
      end
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_reset_map();
      rd_chk(32'h0000_0000, 32'h0000_0000);
      rd_chk(32'h0000_0004, 32'h0000_0000);
      rd_chk(32'h0000_0008, 32'h0000_0020);
      bus(32'h0000_0030, 1'b1, 32'hffff_ffff);
      rd_chk(32'h0000_0030, 32'h0000_0000);
      $display("test reset_map done");
   endtask

   task automatic t_first_conv();
      int len;
      bus(32'h0000_0004, 1'b1, 32'h0000_0003);
      bus(32'h0000_0000, 1'b1, 32'h0000_0003);
      wait_active(1'b1);
      t1 = t0;
      // the selection is rewritten only once a converter clock has passed since start
      bus(32'h0000_0004, 1'b1, 32'h0000_0085);
      @(negedge clk_sys_in);
      chk({25'h0, applied}, 32'h0000_0003);
      rd_chk(32'h0000_0000, 32'h0000_0003);
      wait_active(1'b0);
      len = t0 - t1;
      chk(len, 32'd50);
      @(negedge clk_sys_in);
      chk({25'h0, applied}, 32'h0000_0045);
      rd_chk(32'h0000_0000, 32'h0000_0009);
      $display("test first_conv done");
   endtask

   task automatic t_diff();
      int len;
      bus(32'h0000_0000, 1'b1, 32'h0000_000b);
      conv_len(len);
      chk(len, 32'd26);
      // no result is taken from conversions while the gain stage settles
      bus(32'h0000_0004, 1'b1, 32'h0000_0008);
      // start just after the half-rate clock falls, then just after it rises
      wait_half(1'b0);
      bus(32'h0000_0000, 1'b1, 32'h0000_000b);
      conv_len(len);
      chk(len, 32'd26);
      wait_half(1'b1);
      bus(32'h0000_0000, 1'b1, 32'h0000_000b);
      conv_len(len);
      chk(len, 32'd28);
      $display("test diff done");
   endtask

   task automatic t_free_run();
      bus(32'h0000_0000, 1'b1, 32'h0000_002f);
      wait_sh(t1);
      wait_sh(t2);
      wait_sh(t3);
      chk(t3 - t2, 32'd28);
      bus(32'h0000_0004, 1'b1, 32'h0000_0003);
      @(negedge clk_sys_in);
      chk({25'h0, applied}, 32'h0000_0008);
      rd_chk(32'h0000_0000, 32'h0000_002f);
      bus(32'h0000_0000, 1'b1, 32'h0000_0008);
      repeat (6) @(posedge clk_sys_in);
      rd_chk(32'h0000_0008, 32'h0000_0620);
      chk({31'h0, half}, 32'h0);
      $display("test free_run done");
   endtask

   task automatic t_trigger();
      int len;
      bus(32'h0000_0000, 1'b1, 32'h0000_0005);
      pulse_trig();
      conv_len(len);
      chk(len, 32'd50);
      pulse_trig();
      wait_active(1'b1);
      t1 = t0;
      pulse_trig();
      wait_active(1'b0);
      chk(t0 - t1, 32'd26);
      repeat (10) @(negedge clk_sys_in);
      chk({31'h0, active}, 32'h0);
      $display("test trigger done");
   endtask

   task automatic t_sleep();
      int len;
      // idle mode first, then noise reduction mode
      for (int m = 1; m < 3; m++) begin
         bus(32'h0000_0000, 1'b1, 32'h0000_0019);
         @(negedge clk_sys_in);
         chk({31'h0, irq}, 32'h0);
         @(posedge clk_sys_in);
         sleep <= m[1:0];
         halted <= 1'b1;
         conv_len(len);
         chk(len, 32'd26);
         @(negedge clk_sys_in);
         chk({31'h0, irq}, 32'h1);
         @(posedge clk_sys_in);
         halted <= 1'b0;
         sleep <= 2'b00;
      end
      bus(32'h0000_0000, 1'b1, 32'h0000_0019);
      @(posedge clk_sys_in);
      sleep <= 2'b11;
      halted <= 1'b1;
      repeat (60) @(negedge clk_sys_in);
      chk({31'h0, active}, 32'h0);
      rd_chk(32'h0000_0000, 32'h0000_0011);
      @(posedge clk_sys_in);
      halted <= 1'b0;
      sleep <= 2'b00;
      $display("test sleep done");
   endtask

   // clock enable low for 20 cycles stretches a 13-clock conversion by as much
   task automatic t_freeze();
      int len;
      logic h;
      bus(32'h0000_0000, 1'b1, 32'h0000_0003);
      wait_active(1'b1);
      t1 = t0;
      @(posedge clk_sys_in);
      ce <= 1'b0;
      @(negedge clk_sys_in);
      h = half;
      repeat (20) @(posedge clk_sys_in);
      ce <= 1'b1;
      @(negedge clk_sys_in);
      chk({31'h0, half}, {31'h0, h});
      wait_active(1'b0);
      len = t0 - t1;
      chk(len, 32'd46);
      $display("test freeze done");
   endtask

   task automatic t_pins();
      chk({28'h0, pins}, 32'h0000_000f);
      @(posedge clk_sys_in);
      tif <= 1'b1;
      repeat (4) @(negedge clk_sys_in);
      chk({28'h0, pins}, 32'h0000_0000);
      @(posedge clk_sys_in);
      tif <= 1'b0;
      repeat (4) @(negedge clk_sys_in);
      chk({28'h0, pins}, 32'h0000_000f);
      $display("test pins done");
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      reset_in = 1'b1;
      hsel = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0000_0000;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      trig = 1'b0;
      sleep = 2'b00;
      halted = 1'b0;
      tif = 1'b0;
      ce = 1'b1;
      repeat (4) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      t_reset_map();
      t_first_conv();
      t_diff();
      t_free_run();
      t_trigger();
      t_sleep();
      t_freeze();
      t_pins();
      tally_and_finish();
   end
endmodule // tb
